// ===== core/dczc_pkg.sv
package dczc_pkg;

  localparam int ADDR_W = 24;
  localparam int AXI_AW = 10;
  localparam int IDX_W = 8;
  localparam int CTRL_W = 8;
  localparam int IO_W = 8;
  localparam int TIMER_N = 4;

  // Register indices; byte address is index shifted left by two
  localparam logic [IDX_W-1:0] IDX_MEM_A = 8'h20;
  localparam logic [IDX_W-1:0] IDX_CTRL_A = 8'h27;
  localparam logic [IDX_W-1:0] IDX_MEM_B = 8'h28;
  localparam logic [IDX_W-1:0] IDX_IO_B = 8'h2E;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 8'h2F;
  localparam logic [IDX_W-1:0] IDX_CFG = 8'h30;
  localparam logic [IDX_W-1:0] IDX_STAT = 8'h31;
  localparam int IDX_LSB = 2;

  // Control register fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_SIZE = 6;
  localparam int BIT_DIR = 5;
  localparam int BIT_STEP = 4;
  localparam int BIT_IE = 3;
  localparam int BIT_TMS = 3;
  localparam int BIT_BLOCK = 0;
  localparam logic [1:0] CODE_FULL_HI = 2'h3;

  // Activation codes
  localparam logic [2:0] CODE_AUTO_BURST = 3'h0;
  localparam logic [2:0] CODE_AUTO_STEAL = 3'h2;
  localparam logic [2:0] CODE_TIMER_LAST = 3'h3;
  localparam logic [2:0] CODE_SER_TX = 3'h4;
  localparam logic [2:0] CODE_SER_RX = 3'h5;
  localparam logic [2:0] CODE_EXT_FALL = 3'h6;
  localparam logic [2:0] CODE_EXT_LOW = 3'h7;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MEM_TOP = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 24'h000000;
  localparam logic [IO_W-1:0] IO_RESET = 8'h00;
  localparam int STEP_BYTE = 1;
  localparam int STEP_WORD = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_GAP = 2'b11
  } dczc_state_type;

  typedef enum logic [1:0] {
    MODE_IO = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_IDLE = 2'b10,
    MODE_FULL = 2'b11
  } dczc_mode_type;

endpackage : dczc_pkg

// ===== core/dczc_addr_step.sv
module dczc_addr_step #(
  parameter int AW = 24
) (
  input wire logic [AW-1:0] addrIn,
  input wire logic stepEnable,
  input wire logic stepDown,
  input wire logic wordSize,
  output logic [AW-1:0] addrOut
);

  logic [AW-1:0] delta;

  assign delta = wordSize ? AW'(dczc_pkg::STEP_WORD) : AW'(dczc_pkg::STEP_BYTE);

  always_comb
  begin
    if (!stepEnable)
      addrOut = addrIn;
    else if (stepDown)
      addrOut = addrIn - delta;
    else
      addrOut = addrIn + delta;
  end

endmodule : dczc_addr_step

// ===== core/dczc_channel.sv
// Contract
// - Full mode: source address held when source step enable is 0.
// - Source step up: add 1 per byte, 2 per word.
// - Source step down: subtract 1 per byte, 2 per word.
// - Transfers only while enable bit set; size bit selects byte or word.
// - Memory address B: top byte reads all ones, lower 24 bits writable.
// - I/O address used in short mode, ignored in full mode.
// - Short mode codes 0-3 start on timer channels 0-3.
// - Short mode codes 4, 5 start on serial transmit-empty, receive-full.
// - Short mode codes 6, 7 start on request pin falling edge, low level.
// - End-of-transfer interrupt only when interrupt enable bit is 1.
// - Short mode: I/O, repeat or idle mode from repeat and interrupt enables.
// - Short mode memory address steps up or down by 1 or 2.
// - Full normal mode: code 0 burst, code 2 cycle-steal; 1,3,4,5 unavailable.
// - Full normal mode: codes 6, 7 use pin falling edge, low level.
// - Full block mode: codes 0-3 timers, code 6 pin falling edge only.
// - Block area is destination when mode select 0, source when 1.
// - Full mode runs only while master enable bit is 1.
// - Destination stepping follows the same rule as source stepping.
module dczc_channel (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [dczc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dczc_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [dczc_pkg::TIMER_N-1:0] timerMatch,
  input wire logic serialTxEmpty,
  input wire logic serialRxFull,
  input wire logic extReqN,
  input wire logic xferAck,
  input wire logic xferLast,
  output logic xferReq,
  output logic xferChan,
  output logic xferWord,
  output logic xferFull,
  output logic xferBlockSrc,
  output logic [1:0] xferMode,
  output logic [dczc_pkg::ADDR_W-1:0] xferMemAddr,
  output logic [dczc_pkg::ADDR_W-1:0] xferPeerAddr,
  output logic [dczc_pkg::IO_W-1:0] xferIoAddr,
  output logic xferEndIrq
);

  localparam int AW = dczc_pkg::ADDR_W;

  logic rstMeta_reg;
  logic rstSync_reg;
  logic rstN;
  logic [dczc_pkg::CTRL_W-1:0] ctrl_reg [2];
  logic [AW-1:0] mem_reg [2];
  logic [AW-1:0] memStep [2];
  logic [dczc_pkg::IO_W-1:0] ioB_reg;
  logic blockMode_reg;
  logic [1:0] pend_reg;
  logic [1:0] done_reg;
  logic extPrev_reg;
  logic awHave_reg;
  logic wHave_reg;
  logic [dczc_pkg::AXI_AW-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  dczc_pkg::dczc_state_type state_reg;
  logic doWrite;
  logic [dczc_pkg::IDX_W-1:0] wIdx;
  logic fullMode;
  logic extFall;
  logic extLow;
  logic [1:0] active;
  logic [1:0] trig;
  logic [2:0] codeA;
  logic [2:0] codeB;
  logic ackHit;
  logic [1:0] stepEn;
  logic [1:0] sizeWord;
  logic pickB;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end

  assign rstN = rstSync_reg;

  function automatic logic [dczc_pkg::IDX_W-1:0] regIndex(
    input logic [dczc_pkg::AXI_AW-1:0] addr
  );
    regIndex = addr[dczc_pkg::IDX_LSB +: dczc_pkg::IDX_W];
  endfunction : regIndex

  function automatic logic regMapped(input logic [dczc_pkg::AXI_AW-1:0] addr);
    logic [dczc_pkg::IDX_W-1:0] idx;
    idx = regIndex(addr);
    regMapped = (addr[dczc_pkg::IDX_LSB-1:0] == '0) &&
      (idx == dczc_pkg::IDX_MEM_A || idx == dczc_pkg::IDX_CTRL_A ||
       idx == dczc_pkg::IDX_MEM_B || idx == dczc_pkg::IDX_IO_B ||
       idx == dczc_pkg::IDX_CTRL_B || idx == dczc_pkg::IDX_CFG ||
       idx == dczc_pkg::IDX_STAT);
  endfunction : regMapped

  function automatic dczc_pkg::dczc_mode_type shortMode(
    input logic [dczc_pkg::CTRL_W-1:0] c
  );
    if (!c[dczc_pkg::BIT_STEP])
      shortMode = dczc_pkg::MODE_IO;
    else if (!c[dczc_pkg::BIT_IE])
      shortMode = dczc_pkg::MODE_REPEAT;
    else
      shortMode = dczc_pkg::MODE_IDLE;
  endfunction : shortMode

  // Short-address activation decode, shared by both sub-channels
  function automatic logic shortTrig(
    input logic [2:0] code,
    input logic [dczc_pkg::TIMER_N-1:0] tm,
    input logic tx,
    input logic rx,
    input logic fall,
    input logic low
  );
    case (code)
      dczc_pkg::CODE_SER_TX: shortTrig = tx;
      dczc_pkg::CODE_SER_RX: shortTrig = rx;
      dczc_pkg::CODE_EXT_FALL: shortTrig = fall;
      dczc_pkg::CODE_EXT_LOW: shortTrig = low;
      default: shortTrig = tm[code[1:0]];
    endcase
  endfunction : shortTrig

  // Full-address activation decode; unavailable codes never fire
  function automatic logic fullTrig(
    input logic [2:0] code,
    input logic block,
    input logic [dczc_pkg::TIMER_N-1:0] tm,
    input logic fall,
    input logic low
  );
    fullTrig = 1'b0;
    if (block)
    begin
      if (code <= dczc_pkg::CODE_TIMER_LAST)
        fullTrig = tm[code[1:0]];
      else if (code == dczc_pkg::CODE_EXT_FALL)
        fullTrig = fall;
    end
    else
    begin
      case (code)
        dczc_pkg::CODE_AUTO_BURST: fullTrig = 1'b1;
        dczc_pkg::CODE_AUTO_STEAL: fullTrig = 1'b1;
        dczc_pkg::CODE_EXT_FALL: fullTrig = fall;
        dczc_pkg::CODE_EXT_LOW: fullTrig = low;
        default: fullTrig = 1'b0;
      endcase
    end
  endfunction : fullTrig

  assign codeA = ctrl_reg[0][2:0];
  assign codeB = ctrl_reg[1][2:0];
  assign fullMode = (codeA[2:1] == dczc_pkg::CODE_FULL_HI);
  assign extLow = !extReqN;
  assign extFall = extPrev_reg && !extReqN;
  assign ackHit = (state_reg == dczc_pkg::ST_REQ) && xferAck;
  assign pickB = !(pend_reg[0] && active[0]);

  always_comb
  begin
    if (fullMode)
    begin
      active[0] = ctrl_reg[0][dczc_pkg::BIT_ENABLE] &&
        ctrl_reg[1][dczc_pkg::BIT_ENABLE];
      active[1] = 1'b0;
      trig[0] = fullTrig(codeB, blockMode_reg, timerMatch, extFall, extLow);
      trig[1] = 1'b0;
      stepEn[0] = ctrl_reg[0][dczc_pkg::BIT_STEP];
      stepEn[1] = ctrl_reg[1][dczc_pkg::BIT_STEP];
      sizeWord[0] = ctrl_reg[0][dczc_pkg::BIT_SIZE];
      sizeWord[1] = ctrl_reg[0][dczc_pkg::BIT_SIZE];
    end
    else
    begin
      active[0] = ctrl_reg[0][dczc_pkg::BIT_ENABLE];
      active[1] = ctrl_reg[1][dczc_pkg::BIT_ENABLE];
      trig[0] = shortTrig(codeA, timerMatch, serialTxEmpty, serialRxFull,
        extFall, extLow);
      trig[1] = shortTrig(codeB, timerMatch, serialTxEmpty, serialRxFull,
        extFall, extLow);
      // Idle mode keeps the memory address where it is
      stepEn[0] = shortMode(ctrl_reg[0]) != dczc_pkg::MODE_IDLE;
      stepEn[1] = shortMode(ctrl_reg[1]) != dczc_pkg::MODE_IDLE;
      sizeWord[0] = ctrl_reg[0][dczc_pkg::BIT_SIZE];
      sizeWord[1] = ctrl_reg[1][dczc_pkg::BIT_SIZE];
    end
  end

  for (genvar i = 0; i < 2; i++)
  begin : gStep
    dczc_addr_step #(
      .AW(AW)
    ) uStep (
      .addrIn(mem_reg[i]),
      .stepEnable(stepEn[i]),
      .stepDown(ctrl_reg[i][dczc_pkg::BIT_DIR]),
      .wordSize(sizeWord[i]),
      .addrOut(memStep[i])
    );
  end

  // Register bus: write channels
  assign doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
  assign wIdx = regIndex(awAddr_reg);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dczc_pkg::RESP_OKAY;
    end
    else
    begin
      if (!awHave_reg && !s_axi_bvalid)
        s_axi_awready <= !(s_axi_awvalid && s_axi_awready);
      if (!wHave_reg && !s_axi_bvalid)
        s_axi_wready <= !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= regMapped(awAddr_reg) ? dczc_pkg::RESP_OKAY : dczc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control registers: software writes win, hardware drops the enable at the end in I/O and full modes
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_reg[0] <= dczc_pkg::CTRL_RESET;
      ctrl_reg[1] <= dczc_pkg::CTRL_RESET;
      blockMode_reg <= 1'b0;
      ioB_reg <= dczc_pkg::IO_RESET;
    end
    else
    begin
      if (ackHit && xferLast && (fullMode || shortMode(ctrl_reg[xferChan]) ==
          dczc_pkg::MODE_IO))
        ctrl_reg[xferChan][dczc_pkg::BIT_ENABLE] <= 1'b0;
      if (doWrite && regMapped(awAddr_reg) && wStrb_reg[0])
      begin
        case (wIdx)
          dczc_pkg::IDX_CTRL_A: ctrl_reg[0] <= wData_reg[dczc_pkg::CTRL_W-1:0];
          dczc_pkg::IDX_CTRL_B: ctrl_reg[1] <= wData_reg[dczc_pkg::CTRL_W-1:0];
          dczc_pkg::IDX_IO_B: ioB_reg <= wData_reg[dczc_pkg::IO_W-1:0];
          dczc_pkg::IDX_CFG: blockMode_reg <= wData_reg[dczc_pkg::BIT_BLOCK];
          default: ioB_reg <= ioB_reg;
        endcase
      end
    end
  end

  // Memory address registers: lower 24 bits only; top byte is constant
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      mem_reg[0] <= dczc_pkg::ADDR_RESET;
      mem_reg[1] <= dczc_pkg::ADDR_RESET;
    end
    else
    begin
      if (ackHit)
      begin
        mem_reg[xferChan] <= memStep[xferChan];
        if (fullMode)
          mem_reg[1] <= memStep[1];
      end
      if (doWrite && (wIdx == dczc_pkg::IDX_MEM_A || wIdx == dczc_pkg::IDX_MEM_B) &&
          regMapped(awAddr_reg))
      begin
        for (int b = 0; b < 3; b++)
        begin
          if (wStrb_reg[b])
            mem_reg[wIdx == dczc_pkg::IDX_MEM_B][b*8 +: 8] <= wData_reg[b*8 +: 8];
        end
      end
    end
  end

  // Pending requests and done flags; a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pend_reg <= 2'b00;
      done_reg <= 2'b00;
      extPrev_reg <= 1'b1;
    end
    else
    begin
      extPrev_reg <= extReqN;
      for (int i = 0; i < 2; i++)
      begin
        if (doWrite && wIdx == dczc_pkg::IDX_STAT && regMapped(awAddr_reg) &&
            wStrb_reg[0] && wData_reg[i])
          done_reg[i] <= 1'b0;
        if (ackHit && xferChan == 1'(i) && xferLast)
          done_reg[i] <= 1'b1;
        if (!active[i])
          pend_reg[i] <= 1'b0;
        else if (trig[i])
          pend_reg[i] <= 1'b1;
        else if (ackHit && xferChan == 1'(i))
          pend_reg[i] <= 1'b0;
      end
    end
  end

  // Transfer sequencer; sub-channel A wins a tie
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_reg <= dczc_pkg::ST_IDLE;
      xferReq <= 1'b0;
      xferChan <= 1'b0;
      xferWord <= 1'b0;
      xferFull <= 1'b0;
      xferBlockSrc <= 1'b0;
      xferMode <= dczc_pkg::MODE_IO;
      xferMemAddr <= '0;
      xferPeerAddr <= '0;
      xferIoAddr <= '0;
    end
    else
    begin
      case (state_reg)
        dczc_pkg::ST_IDLE:
        begin
          if ((pend_reg[0] && active[0]) || (pend_reg[1] && active[1]))
          begin
            state_reg <= dczc_pkg::ST_REQ;
            xferReq <= 1'b1;
            xferChan <= pickB;
            xferWord <= sizeWord[pickB];
            xferFull <= fullMode;
            xferMode <= fullMode ? dczc_pkg::MODE_FULL : shortMode(ctrl_reg[pickB]);
            xferBlockSrc <= fullMode && blockMode_reg &&
              ctrl_reg[1][dczc_pkg::BIT_TMS];
            xferMemAddr <= mem_reg[pickB];
            xferPeerAddr <= fullMode ? mem_reg[1] : '0;
            // I/O address only applies to sub-channel B in short mode
            xferIoAddr <= (!fullMode && pickB) ? ioB_reg : '0;
          end
        end
        dczc_pkg::ST_REQ:
        begin
          if (xferAck)
          begin
            xferReq <= 1'b0;
            // Cycle-steal leaves the bus free for two cycles between transfers, one more than burst
            if (xferFull && !blockMode_reg && codeB == dczc_pkg::CODE_AUTO_STEAL)
              state_reg <= dczc_pkg::ST_GAP;
            else
              state_reg <= dczc_pkg::ST_IDLE;
          end
        end
        dczc_pkg::ST_GAP: state_reg <= dczc_pkg::ST_IDLE;
        default: state_reg <= dczc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      xferEndIrq <= 1'b0;
    else
      xferEndIrq <= (done_reg[0] && ctrl_reg[0][dczc_pkg::BIT_IE]) ||
        (done_reg[1] && !fullMode && ctrl_reg[1][dczc_pkg::BIT_IE]);
  end

  // Register bus: read channel, one-cycle answer
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dczc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= regMapped(s_axi_araddr) ? dczc_pkg::RESP_OKAY : dczc_pkg::RESP_SLVERR;
      s_axi_rdata <= '0;
      if (regMapped(s_axi_araddr))
      begin
        case (regIndex(s_axi_araddr))
          dczc_pkg::IDX_MEM_A: s_axi_rdata <= {dczc_pkg::MEM_TOP, mem_reg[0]};
          dczc_pkg::IDX_MEM_B: s_axi_rdata <= {dczc_pkg::MEM_TOP, mem_reg[1]};
          dczc_pkg::IDX_CTRL_A: s_axi_rdata <= 32'(ctrl_reg[0]);
          dczc_pkg::IDX_CTRL_B: s_axi_rdata <= 32'(ctrl_reg[1]);
          dczc_pkg::IDX_IO_B: s_axi_rdata <= 32'(ioB_reg);
          dczc_pkg::IDX_CFG: s_axi_rdata <= 32'(blockMode_reg);
          dczc_pkg::IDX_STAT: s_axi_rdata <= 32'({state_reg, pend_reg, done_reg});
          default: s_axi_rdata <= '0;
        endcase
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end

endmodule : dczc_channel

// ===== sim/dczc_asserts.sv
module dczc_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic xferReq,
  input wire logic xferAck,
  input wire logic xferFull,
  input wire logic xferChan,
  input wire logic xferWord,
  input wire logic [1:0] xferMode,
  input wire logic [23:0] xferMemAddr,
  input wire logic [23:0] xferPeerAddr,
  input wire logic [7:0] xferIoAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking ckDef @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  a_req_stands: assert property (xferReq && !xferAck |=> xferReq &&
    $stable({xferMemAddr, xferPeerAddr, xferWord, xferMode})) else $error("request moved");
  a_req_ends: assert property (xferReq && xferAck |=> !xferReq)
    else $error("request outlived ack");
  a_io_unused: assert property (xferReq && xferFull |-> xferIoAddr == 8'h00)
    else $error("io address in full mode");
  a_full_kind: assert property (xferReq && xferFull |-> xferMode == 2'h3 && !xferChan)
    else $error("full transfer mislabelled");
  a_peer_short: assert property (xferReq && !xferFull |-> xferPeerAddr == 24'h000000)
    else $error("peer address in short mode");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("late write response");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read data");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read data");
  c_full: cover property (xferReq && xferAck && xferFull);
  c_short_b: cover property (xferReq && xferAck && xferChan);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : dczc_asserts

bind dczc_channel dczc_asserts chk (.*);

// ===== sim/dczc_partner.sv
module dczc_partner (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic xferReq,
  input wire logic lastOn,
  input wire logic [1:0] delay,
  output logic xferAck,
  output logic xferLast
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] waitReg;

  // Answers only a standing request, after 0 to 3 extra cycles
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      waitReg <= 3'h0;
      xferAck <= 1'h0;
    end
    else if (xferAck || !xferReq)
    begin
      waitReg <= 3'h0;
      xferAck <= 1'h0;
    end
    else if (waitReg >= {1'h0, delay})
      xferAck <= 1'h1;
    else
      waitReg <= waitReg + 3'h1;
  assign xferLast = xferAck && lastOn;
endmodule : dczc_partner

// ===== sim/tb.sv
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t mismatch %h", $time, (a)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A_MEMA = {dczc_pkg::IDX_MEM_A, 2'h0};
  localparam logic [9:0] A_CTRLA = {dczc_pkg::IDX_CTRL_A, 2'h0};
  localparam logic [9:0] A_MEMB = {dczc_pkg::IDX_MEM_B, 2'h0};
  localparam logic [9:0] A_IOB = {dczc_pkg::IDX_IO_B, 2'h0};
  localparam logic [9:0] A_CTRLB = {dczc_pkg::IDX_CTRL_B, 2'h0};
  localparam logic [9:0] A_CFG = {dczc_pkg::IDX_CFG, 2'h0};
  localparam logic [9:0] A_STAT = {dczc_pkg::IDX_STAT, 2'h0};
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, m, s, seed = 32'h1057C;
  logic [3:0] s_axi_wstrb = 4'hF, timerMatch = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, lastOn = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, xferMode, md, dly = 2'h0;
  logic serialTxEmpty = 1'h0, serialRxFull = 1'h0, extReqN = 1'h1, xferAck, xferLast;
  logic xferReq, xferChan, xferWord, xferFull, xferBlockSrc, xferEndIrq, ok;
  logic [23:0] xferMemAddr, xferPeerAddr;
  logic [7:0] xferIoAddr, ca, cb;
  logic [61:0] tq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors = 0, nCompared = 0, c, n, st, ws;
  wire [61:0] got = {xferMemAddr, xferPeerAddr, xferIoAddr, xferMode, xferWord, xferChan,
    xferFull, xferBlockSrc};

  dczc_channel uut (.*);
  dczc_partner far (.clk(clk), .reset_n(reset_n), .xferReq(xferReq), .lastOn(lastOn),
    .delay(dly), .xferAck(xferAck), .xferLast(xferLast));

  always #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic complete_run();
    $display("errors %0d compared %0d", errors, nCompared);
    if (errors == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic tmo();
    errors++;
    $display("BAD %0t wait expired", $time);
    complete_run();
  endtask : tmo

  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int t;
    bit dn;
    // One edge of gap so a ready is never lowered and raised in one step
    @(posedge clk);
    dn = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (t = 0; t < 40 && !dn; t++)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'h0;
        dn = 1'b1;
      end
    end
    if (!dn) tmo();
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    int t;
    bit dn;
    @(posedge clk);
    dn = 1'b0;
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (t = 0; t < 40 && !dn; t++)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'h0;
        dn = 1'b1;
      end
    end
    if (!dn) tmo();
  endtask : rd

  // Decoy events first, so a wrong source selection shows as a stray transfer
  task automatic fire(input int k);
    timerMatch <= ~(4'h1 << k);
    @(posedge clk);
    timerMatch <= 4'h1 << k;
    serialTxEmpty <= (k == 4);
    serialRxFull <= (k == 5);
    extReqN <= (k < 6);
    @(posedge clk);
    timerMatch <= 4'h0;
    serialTxEmpty <= 1'h0;
    serialRxFull <= 1'h0;
    extReqN <= 1'h1;
    @(posedge clk);
  endtask : fire

  task automatic exp(input int k, input logic [23:0] a, p, input int as, ps,
    input logic [13:0] f);
    repeat (k)
    begin
      tq.push_back({a, p, f});
      a = a + as[23:0];
      p = p + ps[23:0];
    end
    lastOn <= (tq.size() == 1);
  endtask : exp

  // Extra cycles after the queue empties catch stray transfers
  task automatic drain(input int left = 0);
    int t;
    for (t = 0; t < 300 && tq.size() > left; t++)
      @(posedge clk);
    if (tq.size() > left) tmo();
    repeat (6) @(posedge clk);
  endtask : drain

  always @(posedge clk)
  begin
    if (s_axi_rvalid && s_axi_rready)
      `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front())
    if (s_axi_bvalid && s_axi_bready)
      `CHK(s_axi_bresp, bq.pop_front())
    if (xferReq && xferAck)
    begin
      `CHK(tq.size() != 0, 1'h1)
      if (tq.size() != 0)
        `CHK(got, tq.pop_front())
      lastOn <= (tq.size() == 1);
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    wr(10'h3FC, 32'hFF, 2'h2);
    rd(A_CTRLA, 34'h0);
    rd(A_CTRLB, 34'h0);
    rd(10'h3FC, {2'h2, 32'h0});
    for (c = 0; c < 8; c++)
    begin
      m = rnd();
      s = rnd();
      dly <= m[1:0];
      wr(A_MEMB, m);
      wr(A_IOB, s);
      rd(A_MEMB, {10'h0FF, m[23:0]});
      rd(A_IOB, {26'h0, s[7:0]});
      cb = {1'h0, s[14:11], c[2:0]};
      wr(A_CTRLB, cb);
      fire(c);
      cb[7] = 1'h1;
      md = cb[4] ? {cb[3], !cb[3]} : 2'h0;
      st = md == 2'h2 ? 0 : (cb[6] ? 2 : 1) * (cb[5] ? -1 : 1);
      exp(2, m[23:0], 24'h0, st, 0, {s[7:0], md, cb[6], 3'h4});
      wr(A_CTRLB, cb);
      fire(c);
      // An event is only remembered once the standing request is acknowledged
      drain(1);
      fire(c);
      drain();
      wr(A_CTRLB, 32'h0);
    end
    wr(A_STAT, 32'h3);
    for (c = 0; c < 16; c++)
    begin
      m = rnd();
      s = rnd();
      dly <= s[1:0];
      ca = {1'h1, m[30:27], 3'h6};
      cb = {s[26], 1'h0, s[29:27], c[2:0]};
      ok = s[26] && (c[3] ? c[2:0] inside {[3'h0:3'h3], 3'h6}
        : c[2:0] inside {3'h0, 3'h2, 3'h6, 3'h7});
      n = !ok ? 0 : (c[3] || c[2]) ? 1 : 3;
      ws = ca[6] ? 2 : 1;
      exp(n, m[23:0], s[23:0], ca[4] ? ws * (ca[5] ? -1 : 1) : 0,
        cb[4] ? ws * (cb[5] ? -1 : 1) : 0, {8'h0, 2'h3, ca[6], 2'h1, c[3] & cb[3]});
      wr(A_MEMA, m);
      wr(A_MEMB, s);
      wr(A_CFG, 32'(c >> 3));
      wr(A_CTRLB, cb);
      wr(A_CTRLA, ca);
      fire(c & 7);
      drain();
      `CHK(xferEndIrq, ok && ca[3])
      wr(A_CTRLA, 32'h0);
      wr(A_CTRLB, 32'h0);
      wr(A_STAT, 32'h3);
    end
    drain();
    complete_run();
  end
endmodule : tb
